// ### avsr_map.svh
// Register offsets, field positions, reset values and link counts for the slot request block
`ifndef AVSR_MAP_SVH
`define AVSR_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (7-bit command index)
// ----------------------------------------------------------------------------
`define AVSR_REG_PWR_A 7'h26
`define AVSR_REG_PWR_B 7'h2A
`define AVSR_REG_RATE_FIRST 7'h2C
`define AVSR_REG_RATE_LAST 7'h34
`define AVSR_REG_PWR_C 7'h3E

// ----------------------------------------------------------------------------
// Reset values and rate constants
// ----------------------------------------------------------------------------
`define AVSR_PWR_RESET 16'h0000
`define AVSR_RATE_RESET 16'hBB80
`define AVSR_FRAME_RATE_ACC 17'h0BB80

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AVSR_VRA_BIT 0
`define AVSR_VRM_BIT 3
`define AVSR_PD_ADC_BIT 8
`define AVSR_PD_FRONT_BIT 9
`define AVSR_PD_CLFE_BIT 11
`define AVSR_PD_SURR_BIT 11
`define AVSR_PD_MIC_BIT 0
`define AVSR_FV_BIT 15
`define AVSR_CMD_ADDR_TAG 14
`define AVSR_CMD_DATA_TAG 13
`define AVSR_RW_BIT 19

// ----------------------------------------------------------------------------
// Frame geometry and buffering
// ----------------------------------------------------------------------------
`define AVSR_TAG_BITS 5'h10
`define AVSR_SLOT_BITS 5'h14
`define AVSR_FIRST_DATA_SLOT 4'h3
`define AVSR_LAST_SLOT 4'hC
`define AVSR_DONE_SLOT 4'hD
`define AVSR_FRAME_BITS 256
`define AVSR_FIFO_DEPTH 8

`endif

// ### avsr_pkg.sv
// Types shared by the slot request block and its sample buffer
package avsr_pkg;

  // Link framing state
  typedef enum logic {
    LinkIdle,
    LinkFrame
  } avsr_link_state_type;

  // One playback sample tagged with its output slot
  typedef struct packed {
    logic [3:0] slot;
    logic [19:0] sample;
  } avsr_entry_type;

  // Left and right record sample pair
  typedef struct packed {
    logic [19:0] left;
    logic [19:0] right;
  } avsr_pair_type;

endpackage : avsr_pkg

// ### avsr_fifo.sv
// Flip-flop sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module avsr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic inValid, // Write request
  output logic inReady, // Room for a word
  input wire logic [WIDTH-1:0] inData, // Write word
  output logic outValid, // Word available
  input wire logic outReady, // Reader takes word
  output logic [WIDTH-1:0] outData, // Head word
  output logic [$clog2(DEPTH):0] freeCount // Empty places
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("avsr_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Handshake decode
  assign inReady = count_q != DEPTH_C;
  assign outValid = count_q != '0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_q[rdPtr_q];
  assign freeCount = DEPTH_C - count_q;

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule : avsr_fifo

// ### avsr_link_core.sv
// Codec-side link engine: slot request flags, input tags and primary or secondary register access
`timescale 1ns/1ps
`include "avsr_map.svh"
module avsr_link_core #(
  parameter logic [1:0] CODEC_ID = 2'h0, // Zero selects primary
  parameter int FIFO_DEPTH = `AVSR_FIFO_DEPTH // Playback buffer words
) (
  input wire logic clk, // System clock 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic bitClkPin, // Link bit clock pin
  input wire logic syncPin, // Link frame sync pin
  input wire logic sdataOutPin, // Serial data from controller
  output logic sdataInPin, // Serial data to controller
  output logic dacValid, // Playback sample available
  input wire logic dacReady, // Converter takes sample
  output avsr_pkg::avsr_entry_type dacData, // Playback slot and sample
  input wire logic adcValid, // Record pair offered
  output logic adcReady, // Record pair accepted
  input wire avsr_pkg::avsr_pair_type adcData, // Record left and right
  input wire logic micValid, // Mic sample offered
  output logic micReady, // Mic sample accepted
  input wire logic [19:0] micData // Mic sample
);

  localparam int NCH = 5;
  localparam int FAW = $clog2(FIFO_DEPTH);

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  // A pair must fit beside one pending frame of samples
  if (FIFO_DEPTH < 4) begin : g_bad_depth
    $error("avsr_link_core needs a playback buffer of at least 4 words");
  end

  logic [2:0] bclkSync_q;
  logic [1:0] syncSync_q;
  logic [1:0] sdoSync_q;
  logic syncPrev_q;
  avsr_pkg::avsr_link_state_type state_q;
  avsr_pkg::avsr_link_state_type state_d;
  logic [3:0] slotIdx_q;
  logic [4:0] slotBit_q;
  logic [19:0] rxShift_q;
  logic [15:0] rxTag_q;
  logic [19:0] cmdAddr_q;
  logic [15:0] pwrA_q;
  logic [15:0] pwrB_q;
  logic [15:0] pwrC_q;
  logic [15:0] rate_q [NCH];
  logic [15:0] rateRd [NCH];
  logic [16:0] acc_q [NCH];
  logic [12:0] reqSlots_q;
  logic [12:0] expect_q;
  logic rdPend_q;
  logic [6:0] rdAddr_q;
  logic [`AVSR_FRAME_BITS-1:0] txFrame_q;
  logic sdataIn_q;
  logic dacValid_q;
  avsr_pkg::avsr_entry_type dacData_q;
  avsr_pkg::avsr_pair_type hold_q [2];
  logic [1:0] holdFull_q;
  logic [1:0] holdReady_q;

  // ----------------------------------------------------------------------------
  // Pin synchronisers and bit clock edges
  // ----------------------------------------------------------------------------
  // Every pin passes two flops; the third bit clock flop only finds edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclkSync_q <= 3'h0;
      syncSync_q <= 2'h0;
      sdoSync_q <= 2'h0;
    end else begin
      bclkSync_q <= {bclkSync_q[1:0], bitClkPin};
      syncSync_q <= {syncSync_q[0], syncPin};
      sdoSync_q <= {sdoSync_q[0], sdataOutPin};
    end
  end

  // Edge and frame decode
  wire bclkRise = bclkSync_q[1] && !bclkSync_q[2];
  wire bclkFall = !bclkSync_q[1] && bclkSync_q[2];
  wire syncLvl = syncSync_q[1];
  wire sdoLvl = sdoSync_q[1];
  wire frameStart = bclkFall && syncLvl && !syncPrev_q;
  wire inFrame = (state_q == avsr_pkg::LinkFrame) && (slotIdx_q != `AVSR_DONE_SLOT);
  wire sampleBit = bclkFall && !frameStart && inFrame;
  wire [4:0] slotLen = (slotIdx_q == 4'h0) ? `AVSR_TAG_BITS : `AVSR_SLOT_BITS;
  wire lastBit = slotBit_q == (slotLen - 5'h01);
  wire [19:0] rxWord = {rxShift_q[18:0], sdoLvl};
  wire slotDone = sampleBit && lastBit;

  // Link state: idle until the first frame sync
  always_comb begin
    state_d = state_q;
    case (state_q)
      avsr_pkg::LinkIdle: begin
        if (frameStart) begin
          state_d = avsr_pkg::LinkFrame;
        end
      end
      avsr_pkg::LinkFrame: begin
        state_d = avsr_pkg::LinkFrame;
      end
      default: begin
        state_d = avsr_pkg::LinkIdle;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------------------
  // Slot and bit counters restart on every sync rise; bits past slot 12 are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= avsr_pkg::LinkIdle;
      syncPrev_q <= 1'b0;
      slotIdx_q <= `AVSR_DONE_SLOT;
      slotBit_q <= 5'h00;
    end else begin
      state_q <= state_d;
      if (bclkFall) begin
        syncPrev_q <= syncLvl;
      end
      if (frameStart) begin
        slotIdx_q <= 4'h0;
        slotBit_q <= 5'h00;
      end else if (sampleBit) begin
        slotIdx_q <= lastBit ? slotIdx_q + 4'h1 : slotIdx_q;
        slotBit_q <= lastBit ? 5'h00 : slotBit_q + 5'h01;
      end
    end
  end

  // Shift in data, keep output tag and command address words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_q <= 20'h00000;
      rxTag_q <= 16'h0000;
      cmdAddr_q <= 20'h00000;
    end else begin
      if (sampleBit) begin
        rxShift_q <= rxWord;
      end
      if (slotDone && slotIdx_q == 4'h0) begin
        rxTag_q <= rxWord[15:0];
      end else if (frameStart) begin
        rxTag_q <= 16'h0000;
      end
      if (slotDone && slotIdx_q == 4'h1) begin
        cmdAddr_q <= rxWord;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  // Primary needs ID zero plus slot tags; secondary uses its ID instead of the tags
  wire frameValid = rxTag_q[`AVSR_FV_BIT];
  wire idIsMine = rxTag_q[1:0] == CODEC_ID;
  wire addrOk = frameValid && idIsMine && ((CODEC_ID != 2'h0) || rxTag_q[`AVSR_CMD_ADDR_TAG]);
  wire dataOk = frameValid && idIsMine && ((CODEC_ID != 2'h0) || rxTag_q[`AVSR_CMD_DATA_TAG]);
  wire cmdPhase = slotDone && slotIdx_q == 4'h2;
  wire cmdRead = cmdPhase && addrOk && cmdAddr_q[`AVSR_RW_BIT];
  wire cmdWrite = cmdPhase && addrOk && dataOk && !cmdAddr_q[`AVSR_RW_BIT];
  wire [6:0] cmdReg = cmdAddr_q[18:12];
  wire [15:0] cmdData = rxWord[19:4];
  wire variable_rate_enable = pwrB_q[`AVSR_VRA_BIT];
  wire mic_variable_rate_enable = pwrB_q[`AVSR_VRM_BIT];

  // Readback; rate registers show 48k whenever their enable is off
  function automatic logic [15:0] avsr_reg_read(input logic [6:0] a);
    logic [15:0] r;
    logic [6:0] off;
    r = 16'h0000;
    off = a - `AVSR_REG_RATE_FIRST;
    if (a == `AVSR_REG_PWR_A) begin
      r = pwrA_q;
    end else if (a == `AVSR_REG_PWR_B) begin
      r = pwrB_q;
    end else if (a == `AVSR_REG_PWR_C) begin
      r = pwrC_q;
    end else if (a >= `AVSR_REG_RATE_FIRST && a <= `AVSR_REG_RATE_LAST && !a[0]) begin
      r = rateRd[off[3:1]];
    end
    return r;
  endfunction : avsr_reg_read

  // Power and mode registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrA_q <= `AVSR_PWR_RESET;
      pwrB_q <= `AVSR_PWR_RESET;
      pwrC_q <= `AVSR_PWR_RESET;
    end else if (cmdWrite) begin
      if (cmdReg == `AVSR_REG_PWR_A) begin
        pwrA_q <= cmdData;
      end else if (cmdReg == `AVSR_REG_PWR_B) begin
        pwrB_q <= cmdData;
      end else if (cmdReg == `AVSR_REG_PWR_C) begin
        pwrC_q <= cmdData;
      end
    end
  end

  // Read response is echoed in the next input frame; a new read wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_q <= 1'b0;
      rdAddr_q <= 7'h00;
    end else if (cmdRead) begin
      rdPend_q <= 1'b1;
      rdAddr_q <= cmdReg;
    end else if (frameStart) begin
      rdPend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Rate channels: front, centre/LFE, surround, record, mic
  // ----------------------------------------------------------------------------
  logic [NCH-1:0] chEnable;
  logic [NCH-1:0] chPowered;
  logic [NCH-1:0] chNeed;
  logic [NCH-1:0] chGrant;
  logic [2:0] dacGrant;
  logic [2:0] dacReq;
  logic [1:0] adcSend;

  // Mic follows its own enable the way record follows the main one
  assign chEnable = {mic_variable_rate_enable, variable_rate_enable, variable_rate_enable, variable_rate_enable, variable_rate_enable};
  assign chPowered = {!pwrC_q[`AVSR_PD_MIC_BIT], !pwrA_q[`AVSR_PD_ADC_BIT], !pwrC_q[`AVSR_PD_SURR_BIT],
                      !pwrB_q[`AVSR_PD_CLFE_BIT], !pwrA_q[`AVSR_PD_FRONT_BIT]};
  assign chGrant = {holdFull_q, dacGrant};

  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    localparam logic [6:0] RATE_ADDR = 7'(`AVSR_REG_RATE_FIRST + 2 * ch);
    // Fixed rate needs a sample every frame; variable rate when the phase wraps
    assign chNeed[ch] = !chEnable[ch] || (acc_q[ch] >= `AVSR_FRAME_RATE_ACC);
    assign rateRd[ch] = chEnable[ch] ? rate_q[ch] : `AVSR_RATE_RESET;

    // Rate register: writable only while enabled, snaps back to 48k otherwise
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rate_q[ch] <= `AVSR_RATE_RESET;
      end else if (!chEnable[ch]) begin
        rate_q[ch] <= `AVSR_RATE_RESET;
      end else if (cmdWrite && cmdReg == RATE_ADDR) begin
        rate_q[ch] <= cmdData;
      end
    end

    // Phase accumulator; a demand without room is held, not lost
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        acc_q[ch] <= 17'h00000;
      end else if (!chEnable[ch]) begin
        acc_q[ch] <= 17'h00000;
      end else if (frameStart) begin
        if (!chNeed[ch]) begin
          acc_q[ch] <= acc_q[ch] + {1'b0, rate_q[ch]};
        end else if (chGrant[ch] && chPowered[ch]) begin
          acc_q[ch] <= acc_q[ch] - `AVSR_FRAME_RATE_ACC;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Playback request budget
  // ----------------------------------------------------------------------------
  logic [FAW:0] fifoFree;
  logic [7:0] budget;
  logic [7:0] pend;

  // Room must cover samples still due this frame before new pairs are asked for
  always_comb begin
    pend = 8'h00;
    budget = 8'(fifoFree);
    dacGrant = 3'h0;
    for (int s = 0; s < 13; s++) begin
      pend = pend + {7'h00, reqSlots_q[s]};
    end
    budget = (budget > pend) ? budget - pend : 8'h00;
    for (int p = 0; p < 3; p++) begin
      if (chNeed[p] && chPowered[p] && budget >= 8'h02) begin
        dacGrant[p] = 1'b1;
        budget = budget - 8'h02;
      end
    end
  end

  // Requests only for powered pairs; fixed rate asks every frame
  for (genvar p = 0; p < 3; p++) begin : g_req
    assign dacReq[p] = chPowered[p] && (chEnable[p] ? (chNeed[p] && dacGrant[p]) : 1'b1);
  end

  // Slot bits 12..0: pairs on slots 3/4, 6/9, 7/8
  wire [12:0] newReqSlots = {3'h0, dacReq[1], dacReq[2], dacReq[2], dacReq[1], 1'b0, dacReq[0], dacReq[0], 3'h0};
  wire [12:0] livePwrSlots = {3'h0, chPowered[1], chPowered[2], chPowered[2], chPowered[1], 1'b0,
                              chPowered[0], chPowered[0], 3'h0};
  // Flag high means no sample wanted; forced zero when disabled, off or unsupported
  wire [12:0] flagVec = {13{variable_rate_enable}} & livePwrSlots & ~newReqSlots;
  logic [9:0] flagField;
  for (genvar s = 3; s <= 12; s++) begin : g_flag
    assign flagField[12 - s] = flagVec[s];
  end

  // Remember what was asked; those slots are checked in the next output frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSlots_q <= 13'h0000;
      expect_q <= 13'h0000;
    end else if (frameStart) begin
      reqSlots_q <= newReqSlots;
      expect_q <= reqSlots_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Playback capture and buffer
  // ----------------------------------------------------------------------------
  wire slotIsData = slotIdx_q >= `AVSR_FIRST_DATA_SLOT && slotIdx_q <= `AVSR_LAST_SLOT;
  wire [3:0] tagIdx = 4'hF - slotIdx_q;
  // Tagged sample kept only when asked for and the channel is still powered
  wire dataTake = slotDone && slotIsData && frameValid && rxTag_q[tagIdx] && expect_q[slotIdx_q]
                  && livePwrSlots[slotIdx_q];
  wire fifoOutValid;
  wire fifoOutReady = !dacValid_q || dacReady;
  avsr_pkg::avsr_entry_type fifoOutData;
  avsr_pkg::avsr_entry_type fifoInData;
  assign fifoInData = '{slot: slotIdx_q, sample: rxWord};

  // Fixed rate cannot wait: a word arriving into a full buffer is dropped
  avsr_fifo #(
    .WIDTH($bits(avsr_pkg::avsr_entry_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(dataTake),
    .inReady(),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData),
    .freeCount(fifoFree)
  );

  // Registered output stage toward the converters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacValid_q <= 1'b0;
      dacData_q <= '0;
    end else if (fifoOutReady) begin
      dacValid_q <= fifoOutValid;
      dacData_q <= fifoOutData;
    end
  end

  // ----------------------------------------------------------------------------
  // Record and mic holding registers
  // ----------------------------------------------------------------------------
  wire [1:0] holdOffer = {micValid, adcValid};
  avsr_pkg::avsr_pair_type holdIn [2];
  assign holdIn[0] = adcData;
  assign holdIn[1] = '{left: micData, right: 20'h00000};

  for (genvar i = 0; i < 2; i++) begin : g_hold
    // Tag a slot only in a frame that carries a held sample
    assign adcSend[i] = chPowered[3 + i] && holdFull_q[i] && chNeed[3 + i];
    wire load = holdOffer[i] && holdReady_q[i];
    wire fullNext = load || (holdFull_q[i] && !(frameStart && adcSend[i]));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hold_q[i] <= '0;
        holdFull_q[i] <= 1'b0;
        holdReady_q[i] <= 1'b1;
      end else begin
        hold_q[i] <= load ? holdIn[i] : hold_q[i];
        holdFull_q[i] <= fullNext;
        holdReady_q[i] <= !fullNext;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Input frame assembly and serialiser
  // ----------------------------------------------------------------------------
  wire [15:0] txTag = {1'b1, rdPend_q, rdPend_q, adcSend[0], adcSend[0], 1'b0, adcSend[1], 9'h000};
  wire [19:0] txSlot1 = {1'b0, rdPend_q ? rdAddr_q : 7'h00, flagField, 2'h0};
  wire [19:0] txSlot2 = rdPend_q ? {avsr_reg_read(rdAddr_q), 4'h0} : 20'h00000;
  wire [19:0] txSlot3 = adcSend[0] ? hold_q[0].left : 20'h00000;
  wire [19:0] txSlot4 = adcSend[0] ? hold_q[0].right : 20'h00000;
  wire [19:0] txSlot6 = adcSend[1] ? hold_q[1].left : 20'h00000;
  wire [`AVSR_FRAME_BITS-1:0] txNext = {txTag, txSlot1, txSlot2, txSlot3, txSlot4, 20'h00000, txSlot6, 120'h0};

  // Load at the first bit clock falling edge that sees sync high, shift one bit out on each rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txFrame_q <= '0;
      sdataIn_q <= 1'b0;
    end else if (frameStart) begin
      txFrame_q <= txNext;
    end else if (bclkRise && state_q == avsr_pkg::LinkFrame) begin
      sdataIn_q <= txFrame_q[`AVSR_FRAME_BITS-1];
      txFrame_q <= {txFrame_q[`AVSR_FRAME_BITS-2:0], 1'b0};
    end
  end

  // Outputs straight from flops
  assign sdataInPin = sdataIn_q;
  assign dacValid = dacValid_q;
  assign dacData = dacData_q;
  assign adcReady = holdReady_q[0];
  assign micReady = holdReady_q[1];

endmodule : avsr_link_core

// ### avsr_properties.sv
// Port-level assertions for the slot request link block
`timescale 1ns/1ps
module avsr_properties (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic bitClkPin, // Bit clock
  input wire logic syncPin, // Sync
  input wire logic sdataInPin, // To controller
  input wire logic dacValid, // Word ready
  input wire logic dacReady, // Word taken
  input wire avsr_pkg::avsr_entry_type dacData, // Word
  input wire logic adcValid, // Pair offered
  input wire logic adcReady, // Pair free
  input wire logic micValid, // Mic offered
  input wire logic micReady // Mic free
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Handshakes: a word waits intact, a taken pair blocks the next
  dac_hold_a: assert property (dacValid && !dacReady |=> dacValid && $stable(dacData)) else $error("dac word lost");
  dac_drop_a: assert property ($fell(dacValid) |-> $past(dacReady)) else $error("dac word withdrawn");
  dac_slot_a: assert property (dacValid |-> dacData.slot inside {4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9}) else $error("bad slot");
  adc_take_a: assert property (adcValid && adcReady |=> !adcReady) else $error("pair not held");
  mic_take_a: assert property (micValid && micReady |=> !micReady) else $error("mic not held");
  // Serial answer moves only while the bit clock is high, lagging its rise
  sdin_edge_a: assert property ($changed(sdataInPin) |-> bitClkPin) else $error("data off edge");
  ready_bit_a: assert property ($rose(syncPin) |-> ##[14:30] sdataInPin) else $error("no ready bit");
  rst_out_a: assert property ($rose(rst_n) |-> !dacValid && !sdataInPin && adcReady && micReady) else $error("reset out");
  cover property (dacValid && dacReady);
  cover property (adcValid && adcReady);
  cover property ($rose(syncPin));
endmodule : avsr_properties
bind avsr_link_core avsr_properties u_props (.clk, .rst_n, .bitClkPin, .syncPin, .sdataInPin, .dacValid, .dacReady,
  .dacData, .adcValid, .adcReady, .micValid, .micReady);

// ### avsr_ctl.sv
// Behavioural link controller sending one frame per request
`timescale 1ns/1ps
module avsr_ctl (
  input wire logic go, // Toggle starts a frame
  input wire logic [255:0] frameOut, // Frame, slot 0 first
  output logic done, // Toggles at frame end
  output logic [255:0] frameIn, // Received frame
  output logic bitClkPin, // Bit clock
  output logic syncPin, // Sync
  output logic sdataOutPin, // Data to codec
  input wire logic sdataInPin // Data from codec
);
  // Clock stands still between frames; released data idles inverted
  initial begin
    {done, frameIn, bitClkPin, syncPin, sdataOutPin} = '0;
    forever begin
      @(go);
      for (int j = 0; j <= 256; j++) begin
        bitClkPin = 1'b1;
        syncPin = (j < 16);
        sdataOutPin = (j > 0) ? frameOut[256-j] : 1'b0;
        #62.5 bitClkPin = 1'b0;
        if (j > 0) frameIn[256-j] = sdataInPin;
        #62.5;
      end
      sdataOutPin = ~sdataOutPin;
      done = ~done;
    end
  end
endmodule : avsr_ctl

// ### tb_avsr_link_core.sv
// Self-checking bench for the slot request link block
`timescale 1ns/1ps
module tb_avsr_link_core;
  logic clk, rst_n, go = 1'b0, done, bitClkPin, syncPin, sdataOutPin, sdataInPin, sawIdle, secSdi;
  logic dacValid, dacReady, adcValid, adcReady, micValid, micReady;
  logic [19:0] micData;
  logic [255:0] frameOut, frameIn, rx, secRx;
  avsr_pkg::avsr_entry_type dacData;
  avsr_pkg::avsr_pair_type adcData;
  int nErrors = 0;
  int nTests = 0;
  avsr_link_core u_dut (.clk, .rst_n, .bitClkPin, .syncPin, .sdataOutPin, .sdataInPin, .dacValid, .dacReady,
    .dacData, .adcValid, .adcReady, .adcData, .micValid, .micReady, .micData);
  avsr_ctl u_ctl (.go, .frameOut, .done, .frameIn, .bitClkPin, .syncPin, .sdataOutPin, .sdataInPin);
  // Secondary codec on the same link; its answer is collected straight from its pin
  avsr_link_core #(.CODEC_ID(2'h1)) u_sec (.clk, .rst_n, .bitClkPin, .syncPin, .sdataOutPin, .sdataInPin(secSdi),
    .dacValid(), .dacReady(1'b1), .dacData(), .adcValid(1'b0), .adcReady(), .adcData('0), .micValid(1'b0),
    .micReady(), .micData(20'h00000));
  always @(negedge bitClkPin) secRx <= {secRx[254:0], secSdi};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s exp %0h got %0h", name, exp, got);
    end
  endtask : chk
  // One whole frame each way
  task automatic xfer(input logic [15:0] tag, input logic [19:0] s1, s2, s3, s4);
    @(posedge clk);
    frameOut <= {tag, s1, s2, s3, s4, 160'h0};
    go <= ~go;
    @(done);
    rx = frameIn;
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    xfer(16'hE000, {1'b0, a, 12'h000}, {d, 4'h0}, 20'h0, 20'h0);
  endtask : wr
  // Read answer arrives in the following frame
  task automatic rd(input string name, input logic [6:0] a, input logic [15:0] e);
    xfer(16'hC000, {1'b1, a, 12'h000}, 20'h0, 20'h0, 20'h0);
    xfer(16'h8000, 20'h0, 20'h0, 20'h0, 20'h0);
    chk(name, {2'h3, a, e}, {rx[254:253], rx[238:232], rx[219:204]});
  endtask : rd
  task automatic pop(input logic [23:0] e);
    @(posedge clk);
    chk("dacData", {1'b1, e}, {dacValid, dacData});
    dacReady <= 1'b1;
    @(posedge clk);
    dacReady <= 1'b0;
  endtask : pop
  task automatic closeOut;
    if (nErrors == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : closeOut
  // Hang guard, beyond the longest expected run
  initial begin
    #950000;
    nErrors++;
    closeOut();
  end
  initial begin
    {rst_n, go, dacReady, adcValid, micValid, sawIdle} = '0;
    adcData = 40'h123456789A;
    micData = 20'hABCDE;
    frameOut = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    wr(7'h2C, 16'hAC44);
    rd("rateLocked", 7'h2C, 16'hBB80);
    chk("flagsFixed", 64'h0, rx[231:222]);
    xfer(16'h9800, 20'h0, 20'h0, 20'h13579, 20'h2468A);
    pop({4'h3, 20'h13579});
    pop({4'h4, 20'h2468A});
    xfer(16'h1800, 20'h0, 20'h0, 20'h1, 20'h2);
    // Secondary write with frame valid; the primary ignores it and its register 2A stays zero
    xfer(16'hE001, {1'b0, 7'h2A, 12'h000}, {16'h0800, 4'h0}, 20'h0, 20'h0);
    chk("dacNoValid", 64'h0, dacValid);
    rd("idMiss", 7'h2A, 16'h0000);
    // Secondary drops a frame without frame valid, and takes a read tagged by its ID alone
    xfer(16'h0001, {1'b0, 7'h2A, 12'h000}, 20'h0, 20'h0, 20'h0);
    xfer(16'h8001, {1'b1, 7'h2A, 12'h000}, 20'h0, 20'h0, 20'h0);
    wr(7'h26, 16'h0200);
    chk("secRead", {2'h3, 7'h2A, 16'h0800}, {secRx[254:253], secRx[238:232], secRx[219:204]});
    xfer(16'h9800, 20'h0, 20'h0, 20'h11111, 20'h22222);
    chk("dacPowerDown", 64'h0, dacValid);
    wr(7'h26, 16'h0000);
    wr(7'h2A, 16'h0001);
    wr(7'h2C, 16'hAC44);
    rd("rateVar", 7'h2C, 16'hAC44);
    for (int i = 0; i < 4; i++) begin
      xfer(16'h8000, 20'h0, 20'h0, 20'h0, 20'h0);
      sawIdle |= rx[231];
      chk("flagsUnsup", 64'h0, {rx[229], rx[224:222]});
    end
    chk("flagOnDemand", 64'h1, sawIdle);
    wr(7'h2A, 16'h0000);
    rd("rateForced", 7'h2C, 16'hBB80);
    @(posedge clk);
    adcValid <= 1'b1;
    micValid <= 1'b1;
    @(posedge clk);
    while (adcReady !== 1'b1 || micReady !== 1'b1) @(posedge clk);
    adcValid <= 1'b0;
    micValid <= 1'b0;
    xfer(16'h8000, 20'h0, 20'h0, 20'h0, 20'h0);
    chk("recTags", 64'h7, {rx[252:251], rx[249]});
    chk("recData", {adcData, micData}, {rx[199:160], rx[139:120]});
    xfer(16'h8000, 20'h0, 20'h0, 20'h0, 20'h0);
    chk("recIdle", 64'h0, {rx[252:251], rx[249], rx[199:160], rx[139:120]});
    closeOut();
  end
endmodule : tb_avsr_link_core
